/* File: core/mirl_top.sv */
// Interrupt request logic: external latch, oscillator select, timer flags, vector choice
// Assumes one clock mclk, option straps static, timers deliver one-cycle set pulses
//
// Design decisions made here: the register addresses and the plain strobed port.
`include "mirl_regs.svh"

module mirl_top (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	// Register port
	input  wire mirl_pkg::mirl_bus_req_t bus_req,
	output logic [`MIRL_DATA_W-1:0]      bus_rdata,
	// Option straps
	input  wire logic                    trigger_level_option,
	input  wire logic                    porta_irq_option,
	// Interrupt pins
	input  wire logic                    ext_irq_pin_b,
	input  wire logic [3:0]              porta_irq_pins,
	// Timer events and timer data bytes
	input  wire mirl_pkg::mirl_tmr_evt_t tmr_evt,
	input  wire logic [`MIRL_DATA_W-1:0] capture_low_byte,
	input  wire logic [`MIRL_DATA_W-1:0] compare_low_byte,
	input  wire logic [`MIRL_DATA_W-1:0] counter_low_byte,
	// CPU side
	input  wire mirl_pkg::mirl_cpu_req_t cpu_req,
	output mirl_pkg::mirl_cpu_rsp_t      cpu_rsp,
	output logic                         irq_pending,
	// Oscillator control
	output mirl_pkg::mirl_osc_t          osc_ctrl
);
	import mirl_pkg::*;

	localparam int NPIN = 5;

	// Reset release
	logic [1:0] rst_pipe_reg;
	logic       rst_sync_b;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe_reg[1];

	// Pin synchronisers and filtered levels
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_level_reg;
	assign pin_raw = {porta_irq_pins, ext_irq_pin_b};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic [`MIRL_SYNC_STAGES-1:0] sync_reg;
			always_ff @(posedge mclk or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					sync_reg         <= (gi == 0) ? 3'h7 : 3'h0;
					pin_level_reg[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end else begin
					sync_reg <= {sync_reg[1:0], pin_raw[gi]};
					if (sync_reg[1] == sync_reg[2]) begin
						pin_level_reg[gi] <= sync_reg[2];
					end
				end
			end
		end
	endgenerate

	// External source qualification
	logic ded_low;
	logic port_any_high;
	logic ded_act;
	logic port_act;
	logic ded_act_reg;
	logic port_act_reg;
	logic ded_fall;
	logic port_rise;
	logic level_hold;
	logic ext_event;

	assign ded_low       = ~pin_level_reg[0];
	// port pins count only with the option
	assign port_any_high = porta_irq_option & (|pin_level_reg[NPIN-1:1]);
	// first active group locks out the other
	assign ded_act       = ded_low & (ded_act_reg | ~port_any_high);
	assign port_act      = port_any_high & (port_act_reg | ~ded_low);
	// edge needs a return to idle first
	assign ded_fall      = ded_act & ~ded_act_reg;
	// rising edge of the active port group
	assign port_rise     = port_act & ~port_act_reg;
	// level sensing chosen by the strap
	// held level keeps the request present
	assign level_hold    = trigger_level_option & (ded_act | port_act);
	assign ext_event     = ded_fall | port_rise | level_hold;

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ded_act_reg  <= 1'b0;
			port_act_reg <= 1'b0;
		end else begin
			ded_act_reg  <= ded_act;
			port_act_reg <= port_act;
		end
	end

	// Register decode
	logic wr_ext;
	logic wr_ct;
	logic wr_t16c;
	logic rd_ext;
	logic rd_ct;
	logic rd_t16c;
	logic rd_t16s;
	logic rd_cap;
	logic rd_cmp;
	logic rd_cnt;
	logic acc_cap;
	logic acc_cmp;
	logic acc_cnt;
	logic [`MIRL_DATA_W-1:0] wd;

	assign wd      = bus_req.wdata;
	assign wr_ext  = bus_req.wr & (bus_req.addr == `MIRL_OFS_EXT_SC);
	assign wr_ct   = bus_req.wr & (bus_req.addr == `MIRL_OFS_CTSC);
	assign wr_t16c = bus_req.wr & (bus_req.addr == `MIRL_OFS_T16_CTRL);
	assign rd_ext  = bus_req.rd & (bus_req.addr == `MIRL_OFS_EXT_SC);
	assign rd_ct   = bus_req.rd & (bus_req.addr == `MIRL_OFS_CTSC);
	assign rd_t16c = bus_req.rd & (bus_req.addr == `MIRL_OFS_T16_CTRL);
	assign rd_t16s = bus_req.rd & (bus_req.addr == `MIRL_OFS_T16_STAT);
	assign rd_cap  = bus_req.rd & (bus_req.addr == `MIRL_OFS_CAP_LO);
	assign rd_cmp  = bus_req.rd & (bus_req.addr == `MIRL_OFS_CMP_LO);
	assign rd_cnt  = bus_req.rd & (bus_req.addr == `MIRL_OFS_CNT_LO);
	assign acc_cap = rd_cap;
	assign acc_cmp = (bus_req.rd | bus_req.wr) & (bus_req.addr == `MIRL_OFS_CMP_LO);
	assign acc_cnt = (bus_req.rd | bus_req.wr) & (bus_req.addr == `MIRL_OFS_CNT_LO);

	// External status/control register
	logic ext_irq_enable_reg;
	logic osc_select_hi_reg;
	logic osc_select_lo_reg;
	logic ext_irq_flag_reg;
	logic ext_irq_flag_next;
	logic ext_vec_clear;
	logic ext_wr_clear;
	localparam logic [`MIRL_DATA_W-1:0] ext_sc_rst = `MIRL_EXT_SC_RESET;

	assign ext_wr_clear = wr_ext & wd[`MIRL_EXT_CLR_BIT];
	// vector fetch of the external source
	assign ext_vec_clear = cpu_req.vector_fetch & (cpu_rsp.source == MIRL_SRC_EXT);
	// new event wins over any clear
	assign ext_irq_flag_next = ext_event | (ext_irq_flag_reg & ~ext_wr_clear & ~ext_vec_clear);

	// reset sets enable and osc_hi only
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ext_irq_enable_reg <= ext_sc_rst[`MIRL_EXT_EN_BIT];
			osc_select_hi_reg  <= ext_sc_rst[`MIRL_EXT_OSC_HI_BIT];
			osc_select_lo_reg  <= ext_sc_rst[`MIRL_EXT_OSC_LO_BIT];
			ext_irq_flag_reg   <= 1'b0;
		end else begin
			if (wr_ext) begin
				ext_irq_enable_reg <= wd[`MIRL_EXT_EN_BIT];
				osc_select_hi_reg  <= wd[`MIRL_EXT_OSC_HI_BIT];
				osc_select_lo_reg  <= wd[`MIRL_EXT_OSC_LO_BIT];
			end
			ext_irq_flag_reg <= ext_irq_flag_next;
		end
	end

	// Oscillator selection
	// external only with osc_lo set alone
	assign osc_ctrl.cpu_on_ext = osc_select_lo_reg & ~osc_select_hi_reg;
	assign osc_ctrl.lpo_en     = ~osc_ctrl.cpu_on_ext;
	// both set enables external while internal clocks
	assign osc_ctrl.epo_en     = osc_select_lo_reg;

	// Core timer status/control
	logic core_tof_reg;
	logic core_periodic_int_flag_reg;
	logic core_core_ovf_int_enable_reg;
	logic core_periodic_int_enable_reg;
	logic core_tof_clr;
	logic core_periodic_int_flag_clr;

	assign core_tof_clr  = wr_ct & wd[`MIRL_CT_TOFCLR_BIT];
	assign core_periodic_int_flag_clr = wr_ct & wd[`MIRL_CT_RTICLR_BIT];

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			core_tof_reg  <= 1'b0;
			core_periodic_int_flag_reg <= 1'b0;
			core_core_ovf_int_enable_reg <= 1'b0;
			core_periodic_int_enable_reg <= 1'b0;
		end else begin
			core_tof_reg  <= tmr_evt.core_ovf | (core_tof_reg & ~core_tof_clr);
			core_periodic_int_flag_reg <= tmr_evt.periodic | (core_periodic_int_flag_reg & ~core_periodic_int_flag_clr);
			if (wr_ct) begin
				core_core_ovf_int_enable_reg <= wd[`MIRL_CT_CORE_OVF_INT_ENABLE_BIT];
				core_periodic_int_enable_reg <= wd[`MIRL_CT_PERIODIC_INT_ENABLE_BIT];
			end
		end
	end

	// 16-bit timer enables, not touched by reset
	logic t16_cap_en_reg;
	logic t16_cmp_en_reg;
	logic t16_ovf_en_reg;

	// enables hold their value through reset
	always_ff @(posedge mclk) begin
		if (wr_t16c) begin
			t16_cap_en_reg <= wd[`MIRL_T16_CAP_BIT];
			t16_cmp_en_reg <= wd[`MIRL_T16_CMP_BIT];
			t16_ovf_en_reg <= wd[`MIRL_T16_OVF_BIT];
		end
	end

	// 16-bit timer flags with two-step clearing
	logic t16_cap_reg;
	logic t16_cmp_reg;
	logic t16_ovf_reg;
	logic cap_arm_reg;
	logic cmp_arm_reg;
	logic ovf_arm_reg;
	logic cap_clr;
	logic cmp_clr;
	logic ovf_clr;

	// armed status read then capture low read
	assign cap_clr = cap_arm_reg & acc_cap;
	// armed status read then compare low access
	assign cmp_clr = cmp_arm_reg & acc_cmp;
	// armed status read then counter low access
	assign ovf_clr = ovf_arm_reg & acc_cnt;

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			t16_cap_reg <= 1'b0;
			t16_cmp_reg <= 1'b0;
			t16_ovf_reg <= 1'b0;
			cap_arm_reg <= 1'b0;
			cmp_arm_reg <= 1'b0;
			ovf_arm_reg <= 1'b0;
		end else begin
			t16_cap_reg <= tmr_evt.capture | (t16_cap_reg & ~cap_clr);
			t16_cmp_reg <= tmr_evt.compare | (t16_cmp_reg & ~cmp_clr);
			t16_ovf_reg <= tmr_evt.t16_ovf | (t16_ovf_reg & ~ovf_clr);
			cap_arm_reg <= (rd_t16s & t16_cap_reg) | (cap_arm_reg & ~cap_clr);
			cmp_arm_reg <= (rd_t16s & t16_cmp_reg) | (cmp_arm_reg & ~cmp_clr);
			ovf_arm_reg <= (rd_t16s & t16_ovf_reg) | (ovf_arm_reg & ~ovf_clr);
		end
	end

	// Request qualification
	logic ext_req;
	logic core_req;
	logic t16_req;
	logic any_req;

	// mask or disabled enable suppresses external
	// latch, clear mask and enable needed
	assign ext_req  = ext_irq_flag_reg & ext_irq_enable_reg & ~cpu_req.i_mask;
	assign core_req = ~cpu_req.i_mask
		& ((core_tof_reg & core_core_ovf_int_enable_reg) | (core_periodic_int_flag_reg & core_periodic_int_enable_reg));
	assign t16_req  = ~cpu_req.i_mask
		& ((t16_cap_reg & t16_cap_en_reg) | (t16_cmp_reg & t16_cmp_en_reg)
		| (t16_ovf_reg & t16_ovf_en_reg));
	assign any_req  = ext_req | core_req | t16_req;

	// Source choice at an instruction boundary
	mirl_src_t src_next;
	logic      enter_next;

	always_comb begin
		src_next   = MIRL_SRC_NONE;
		enter_next = 1'b0;
		if (cpu_req.instr_done) begin
			if (cpu_req.soft_interrupt_instr) begin
				src_next   = MIRL_SRC_SWI;
				enter_next = 1'b1;
			end else if (ext_req) begin
				src_next   = MIRL_SRC_EXT;
				enter_next = 1'b1;
			end else if (core_req) begin
				src_next   = MIRL_SRC_CORE;
				enter_next = 1'b1;
			end else if (t16_req) begin
				src_next   = MIRL_SRC_T16;
				enter_next = 1'b1;
			end
		end
	end

	logic      enter_reg;
	mirl_src_t src_reg;
	logic      pend_reg;

	// entry pulse and held source for the CPU
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			enter_reg <= 1'b0;
			src_reg   <= MIRL_SRC_NONE;
			pend_reg  <= 1'b0;
		end else begin
			enter_reg <= enter_next;
			pend_reg  <= any_req;
			if (enter_next) begin
				src_reg <= src_next;
			end
		end
	end

	assign cpu_rsp.enter  = enter_reg;
	assign cpu_rsp.source = src_reg;
	assign irq_pending    = pend_reg;

	// Read data
	logic [`MIRL_DATA_W-1:0] rd_mux;
	logic [`MIRL_DATA_W-1:0] rdata_reg;
	logic [`MIRL_DATA_W-1:0] ext_view;
	logic [`MIRL_DATA_W-1:0] ct_view;
	logic [`MIRL_DATA_W-1:0] t16c_view;
	logic [`MIRL_DATA_W-1:0] t16s_view;

	assign ext_view  = {ext_irq_enable_reg, 1'b0, osc_select_hi_reg, osc_select_lo_reg,
		ext_irq_flag_reg, 3'h0};
	assign ct_view   = {core_tof_reg, core_periodic_int_flag_reg, core_core_ovf_int_enable_reg, core_periodic_int_enable_reg, 4'h0};
	assign t16c_view = {t16_cap_en_reg, t16_cmp_en_reg, t16_ovf_en_reg, 5'h00};
	assign t16s_view = {t16_cap_reg, t16_cmp_reg, t16_ovf_reg, 5'h00};
	assign rd_mux    = rd_ext  ? ext_view  :
	                   rd_ct   ? ct_view   :
	                   rd_t16c ? t16c_view :
	                   rd_t16s ? t16s_view :
	                   rd_cap  ? capture_low_byte :
	                   rd_cmp  ? compare_low_byte :
	                   rd_cnt  ? counter_low_byte : 8'h00;

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rd_mux;
		end
	end

	assign bus_rdata = rdata_reg;

endmodule

/* File: core/mirl_regs.svh */
// Register offsets, field positions and reset values of the interrupt request logic
// Assumes an 8-bit register port with byte-wide address
`ifndef MIRL_REGS_SVH
`define MIRL_REGS_SVH

`define MIRL_ADDR_W          8
`define MIRL_DATA_W          8

// Register offsets
`define MIRL_OFS_CTSC        8'h08
`define MIRL_OFS_T16_CTRL    8'h12
`define MIRL_OFS_T16_STAT    8'h13
`define MIRL_OFS_CAP_LO      8'h15
`define MIRL_OFS_CMP_LO      8'h17
`define MIRL_OFS_CNT_LO      8'h19
`define MIRL_OFS_EXT_SC      8'h1a

// External status/control fields
`define MIRL_EXT_EN_BIT      7
`define MIRL_EXT_OSC_HI_BIT  5
`define MIRL_EXT_OSC_LO_BIT  4
`define MIRL_EXT_FLAG_BIT    3
`define MIRL_EXT_CLR_BIT     1
`define MIRL_EXT_SC_RESET    8'ha0

// Core timer status/control fields
`define MIRL_CT_TOF_BIT      7
`define MIRL_CT_PERIODIC_INT_FLAG_BIT     6
`define MIRL_CT_CORE_OVF_INT_ENABLE_BIT     5
`define MIRL_CT_PERIODIC_INT_ENABLE_BIT     4
`define MIRL_CT_TOFCLR_BIT   3
`define MIRL_CT_RTICLR_BIT   2

// 16-bit timer control and status fields
`define MIRL_T16_CAP_BIT     7
`define MIRL_T16_CMP_BIT     6
`define MIRL_T16_OVF_BIT     5

// Pin synchroniser depth
`define MIRL_SYNC_STAGES     3

`endif

/* File: core/mirl_pkg.sv */
// Types shared by the interrupt request logic
// Assumes mirl_regs.svh supplies the widths
`include "mirl_regs.svh"

package mirl_pkg;

	typedef enum logic [2:0] {
		MIRL_SRC_NONE,
		MIRL_SRC_SWI,
		MIRL_SRC_EXT,
		MIRL_SRC_CORE,
		MIRL_SRC_T16
	} mirl_src_t;

	typedef struct packed {
		logic [`MIRL_ADDR_W-1:0] addr;
		logic [`MIRL_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} mirl_bus_req_t;

	typedef struct packed {
		logic instr_done;
		logic soft_interrupt_instr;
		logic i_mask;
		logic vector_fetch;
	} mirl_cpu_req_t;

	typedef struct packed {
		logic      enter;
		mirl_src_t source;
	} mirl_cpu_rsp_t;

	typedef struct packed {
		logic cpu_on_ext;
		logic lpo_en;
		logic epo_en;
	} mirl_osc_t;

	typedef struct packed {
		logic core_ovf;
		logic periodic;
		logic capture;
		logic compare;
		logic t16_ovf;
	} mirl_tmr_evt_t;

endpackage

/* File: tb/mirl_cpu_model.sv */
// CPU core model: retires instructions on request, fetches the vector after entry
// Assumes the bench pulses step and rti for one cycle each
module mirl_cpu_model (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	// Bench control
	input  wire logic                    step,
	input  wire logic                    swi_in,
	input  wire logic                    mask_in,
	input  wire logic                    return_from_interrupt,
	// Design side
	input  wire mirl_pkg::mirl_cpu_rsp_t cpu_rsp,
	output mirl_pkg::mirl_cpu_req_t      cpu_req
);
	timeunit 1ns;
	timeprecision 1ns;
	import mirl_pkg::*;
	logic svc_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_req <= '0;
			svc_reg <= 1'h0;
		end else begin
			cpu_req.instr_done <= step;
			cpu_req.soft_interrupt_instr        <= step & swi_in;
			cpu_req.i_mask     <= mask_in | svc_reg | cpu_rsp.enter;
			cpu_req.vector_fetch <= cpu_rsp.enter;
			svc_reg            <= cpu_rsp.enter | (svc_reg & ~return_from_interrupt);
		end
	end
endmodule

/* File: tb/mirl_top_assertions.sv */
// Checker for the interrupt request logic
// Assumes one clock mclk and the raw active-low reset rst_b
`include "mirl_regs.svh"
module mirl_chk (
	// Clock and reset
	input wire logic                    mclk,
	input wire logic                    rst_b,
	// Register port
	input wire mirl_pkg::mirl_bus_req_t bus_req,
	input wire logic [`MIRL_DATA_W-1:0] bus_rdata,
	// CPU side
	input wire mirl_pkg::mirl_cpu_req_t cpu_req,
	input wire mirl_pkg::mirl_cpu_rsp_t cpu_rsp,
	input wire logic                    irq_pending,
	// Oscillator control
	input wire mirl_pkg::mirl_osc_t     osc_ctrl
);
	timeunit 1ns;
	timeprecision 1ns;
	import mirl_pkg::*;
	logic ext_rd_q;
	logic mask_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ext_rd_q <= 1'h0;
			mask_q   <= 1'h0;
		end else begin
			ext_rd_q <= bus_req.rd && bus_req.addr == `MIRL_OFS_EXT_SC;
			mask_q   <= cpu_req.i_mask;
		end
	end

	swi_enter_a: assert property (cpu_req.instr_done && cpu_req.soft_interrupt_instr
		|=> cpu_rsp.enter && cpu_rsp.source == MIRL_SRC_SWI) else $error("soft entry missing");
	masked_enter_a: assert property (cpu_req.instr_done && cpu_req.i_mask && !cpu_req.soft_interrupt_instr
		|=> !cpu_rsp.enter) else $error("entry while masked");
	enter_cause_a: assert property (cpu_rsp.enter |-> $past(cpu_req.instr_done))
		else $error("entry without instruction end");
	pend_enter_a: assert property (cpu_req.instr_done && !cpu_req.soft_interrupt_instr && !cpu_req.i_mask
		|=> !irq_pending || (cpu_rsp.enter && cpu_rsp.source != MIRL_SRC_NONE))
		else $error("pending request not entered");
	pend_mask_a: assert property (mask_q |-> !irq_pending) else $error("pending while masked");
	enter_once_a: assert property (cpu_rsp.enter |=> !cpu_rsp.enter)
		else $error("entry pulse too long");
	osc_lpo_a: assert property (ext_rd_q |-> osc_ctrl.lpo_en
		== !(bus_rdata[`MIRL_EXT_OSC_LO_BIT] && !bus_rdata[`MIRL_EXT_OSC_HI_BIT]))
		else $error("internal oscillator state wrong");
	osc_ext_a: assert property (osc_ctrl.cpu_on_ext |-> osc_ctrl.epo_en)
		else $error("external clock selected but off");
	ext_unused_a: assert property (ext_rd_q |-> (bus_rdata & 8'h47) == 8'h00)
		else $error("unused bits read nonzero");
endmodule

bind mirl_top mirl_chk u_chk (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
	.irq_pending(irq_pending), .osc_ctrl(osc_ctrl));

/* File: tb/tb.sv */
// Bench for the interrupt request logic
// Assumes mirl_top and the CPU model; drives pins and timer events directly
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mirl_pkg::*;
	logic          mclk = 1'h0;
	logic          rst_b = 1'h0;
	logic          lvl = 1'h0;
	logic          popt = 1'h0;
	logic          pin_b = 1'h1;
	logic [3:0]    pins = 4'h0;
	logic          step = 1'h0;
	logic          soft_interrupt_instr = 1'h0;
	logic          mask = 1'h0;
	logic          return_from_interrupt = 1'h0;
	mirl_bus_req_t bus = '0;
	mirl_tmr_evt_t evt = '0;
	mirl_cpu_req_t creq;
	mirl_cpu_rsp_t crsp;
	mirl_osc_t     osc;
	logic [7:0]    rdata;
	logic          pend;
	int            bad_count = 0;
	int            total_checks = 0;

	always #50 mclk = ~mclk;

	mirl_top dut (.mclk(mclk), .rst_b(rst_b), .bus_req(bus), .bus_rdata(rdata),
		.trigger_level_option(lvl), .porta_irq_option(popt), .ext_irq_pin_b(pin_b),
		.porta_irq_pins(pins), .tmr_evt(evt), .capture_low_byte(8'h5c),
		.compare_low_byte(8'h6d), .counter_low_byte(8'h7e), .cpu_req(creq),
		.cpu_rsp(crsp), .irq_pending(pend), .osc_ctrl(osc));
	mirl_cpu_model u_cpu (.mclk(mclk), .rst_b(rst_b), .step(step), .swi_in(soft_interrupt_instr),
		.mask_in(mask), .return_from_interrupt(return_from_interrupt), .cpu_rsp(crsp), .cpu_req(creq));

	task results;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'h1, 1'h0};
		@(posedge mclk);
		bus.wr <= 1'h0;
	endtask

	task rx(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge mclk);
		bus <= '{a, 8'h00, 1'h0, 1'h1};
		@(posedge mclk);
		bus.rd <= 1'h0;
		@(negedge mclk);
		`CHK(n, e, rdata)
		@(posedge mclk);
	endtask

	task ins(input logic s, input logic e, input mirl_src_t src);
		@(posedge mclk);
		step <= 1'h1;
		soft_interrupt_instr <= s;
		@(posedge mclk);
		step <= 1'h0;
		@(posedge mclk);
		#1 `CHK("enter", e, crsp.enter)
		if (e) `CHK("source", src, crsp.source)
		cyc(2);
		return_from_interrupt <= 1'h1;
		@(posedge mclk);
		return_from_interrupt <= 1'h0;
	endtask

	task pulse(input mirl_tmr_evt_t v);
		@(posedge mclk);
		evt <= v;
		@(posedge mclk);
		evt <= '0;
	endtask

	task t_regs;
		rx(8'h1a, 8'ha0, "ext reset");
		`CHK("lpo", 1'h1, osc.lpo_en)
		rx(8'h3f, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) begin
			wr(8'h1a, 8'h80 | 8'(i << 4));
			#1 `CHK("osc", {i == 1, i != 1, i[0]}, osc)
		end
		wr(8'h1a, 8'hae);
		rx(8'h1a, 8'ha0, "ro bits");
	endtask

	task t_pins;
		pin_b <= 1'h0;
		cyc(6);
		rx(8'h1a, 8'ha8, "fall");
		wr(8'h1a, 8'ha2);
		cyc(6);
		rx(8'h1a, 8'ha0, "held low");
		pin_b <= 1'h1;
		cyc(6);
		pin_b <= 1'h0;
		cyc(6);
		rx(8'h1a, 8'ha8, "refall");
		lvl <= 1'h1;
		wr(8'h1a, 8'ha2);
		cyc(2);
		rx(8'h1a, 8'ha8, "level");
		pin_b <= 1'h1;
		cyc(6);
		wr(8'h1a, 8'ha2);
		rx(8'h1a, 8'ha0, "released");
		lvl <= 1'h0;
	endtask

	task t_cpu;
		pin_b <= 1'h0;
		mask <= 1'h1;
		cyc(6);
		ins(1'h0, 1'h0, MIRL_SRC_NONE);
		mask <= 1'h0;
		wr(8'h1a, 8'h20);
		ins(1'h0, 1'h0, MIRL_SRC_NONE);
		wr(8'h1a, 8'ha0);
		ins(1'h0, 1'h1, MIRL_SRC_EXT);
		rx(8'h1a, 8'ha0, "fetch clear");
		pin_b <= 1'h1;
		mask <= 1'h1;
		ins(1'h1, 1'h1, MIRL_SRC_SWI);
		mask <= 1'h0;
	endtask

	task t_port;
		popt <= 1'h1;
		pins <= 4'h4;
		cyc(6);
		rx(8'h1a, 8'ha8, "port rise");
		wr(8'h1a, 8'ha2);
		pin_b <= 1'h0;
		cyc(6);
		rx(8'h1a, 8'ha0, "pin ignored");
		pin_b <= 1'h1;
		cyc(6);
		rx(8'h1a, 8'ha0, "pin rise ignored");
		pins <= 4'h0;
		cyc(6);
		pin_b <= 1'h0;
		cyc(6);
		wr(8'h1a, 8'ha2);
		pins <= 4'h1;
		cyc(6);
		rx(8'h1a, 8'ha0, "port ignored");
		pins <= 4'h0;
		cyc(6);
		rx(8'h1a, 8'ha0, "port fall ignored");
		pin_b <= 1'h1;
		popt <= 1'h0;
		cyc(6);
	endtask

	task t_core;
		wr(8'h08, 8'h30);
		pulse(5'h10);
		pin_b <= 1'h0;
		cyc(6);
		rx(8'h08, 8'hb0, "ovf flag");
		ins(1'h0, 1'h1, MIRL_SRC_EXT);
		ins(1'h0, 1'h1, MIRL_SRC_CORE);
		pin_b <= 1'h1;
		wr(8'h08, 8'h38);
		pulse(5'h08);
		rx(8'h08, 8'h70, "periodic flag");
		wr(8'h08, 8'h34);
		rx(8'h08, 8'h30, "periodic clear");
	endtask

	task t_t16;
		wr(8'h12, 8'he0);
		pulse(5'h07);
		ins(1'h0, 1'h1, MIRL_SRC_T16);
		rx(8'h13, 8'he0, "t16 flags");
		rx(8'h15, 8'h5c, "cap byte");
		rx(8'h13, 8'h60, "cap clear");
		wr(8'h17, 8'h00);
		rx(8'h13, 8'h20, "cmp clear");
		rx(8'h19, 8'h7e, "cnt byte");
		rx(8'h13, 8'h00, "ovf clear");
		rx(8'h12, 8'he0, "t16 enables");
	endtask

	task t_rst;
		wr(8'h1a, 8'h10);
		pulse(5'h07);
		rst_b <= 1'h0;
		cyc(2);
		rst_b <= 1'h1;
		cyc(3);
		rx(8'h12, 8'he0, "enables kept");
		rx(8'h13, 8'h00, "flags reset");
		rx(8'h1a, 8'ha0, "ext after reset");
	endtask

	initial begin
		#(5000 * 100);
		bad_count++;
		results();
	end

	initial begin
		cyc(8);
		rst_b <= 1'h1;
		cyc(3);
		t_regs();
		t_pins();
		t_cpu();
		t_port();
		t_core();
		t_t16();
		t_rst();
		results();
	end
endmodule
